// ==== binary_compare_flag_unit.sv ====
// Compare datapath driving the arithmetic result flags, with Avalon-MM register access.
`timescale 1ns/10ps
module binary_compare_flag_unit (
  input  wire logic                          i_clock,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_exec_valid,
  output logic                               o_exec_ready,
  input  wire compare_pkg::compare_req_t     i_exec_req,
  output logic                               o_done,
  output logic                               o_reject,
  input  wire logic [compare_pkg::WORD_W-1:0] i_input_word,
  output compare_pkg::result_flags_t         o_flags,
  output logic                               o_error_flag_out,
  output logic                               o_negative_flag,
  input  wire logic [compare_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [compare_pkg::BUS_W-1:0] i_avs_writedata,
  input  wire logic [3:0]                    i_avs_byteenable,
  output logic [compare_pkg::BUS_W-1:0]      o_avs_readdata,
  output logic                               o_avs_waitrequest
);
  import compare_pkg::*;

  compare_state_t          state_ff;
  compare_state_t          nxt_state;
  compare_req_t            req_ff;
  result_flags_t           flags_ff;
  logic                    error_ff;
  logic                    negative_ff;
  logic                    done_ff;
  logic                    reject_ff;
  logic                    enable_ff;
  logic [COUNT_W-1:0]      count_ff;
  logic [WORD_W-1:0]       input_meta_ff;
  logic [WORD_W-1:0]       input_sync_ff;
  logic                    ack_ff;
  logic [BUS_W-1:0]        readdata_ff;
  logic                    accept;
  logic                    bad_req;
  logic                    bus_req;
  logic                    bus_write;
  logic                    flags_write;
  result_flags_t           nxt_flags;

  // Flag pattern from one outcome; all six are always rewritten together
  function automatic result_flags_t outcome_flags(input logic gt, input logic eq);
    result_flags_t f;
    f.greater_flag       = gt;
    f.greater_equal_flag = gt | eq;
    f.equal_flag         = eq;
    f.not_equal_flag     = ~eq;
    f.less_flag          = ~gt & ~eq;
    f.less_equal_flag    = ~gt;
    return f;
  endfunction

  function automatic result_flags_t compare_fn(input compare_op_t op, input operand_t a,
                                               input operand_t b);
    logic gt;
    logic eq;
    gt = 1'b0;
    eq = 1'b0;
    case (op)
      OP_UNSIGNED_WORD: begin
        gt = a.lower > b.lower;
        eq = a.lower == b.lower;
      end
      OP_UNSIGNED_DOUBLE: begin
        gt = {a.upper, a.lower} > {b.upper, b.lower};
        eq = {a.upper, a.lower} == {b.upper, b.lower};
      end
      OP_SIGNED_WORD: begin
        gt = $signed(a.lower) > $signed(b.lower);
        eq = a.lower == b.lower;
      end
      OP_SIGNED_DOUBLE: begin
        gt = $signed({a.upper, a.lower}) > $signed({b.upper, b.lower});
        eq = {a.upper, a.lower} == {b.upper, b.lower};
      end
      default: begin
        gt = 1'b0;
        eq = 1'b0;
      end
    endcase
    return outcome_flags(gt, eq);
  endfunction

  // Input word comes from pins; only the second stage is read
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      input_meta_ff <= WORD_RESET;
      input_sync_ff <= WORD_RESET;
    end else begin
      input_meta_ff <= i_input_word;
      input_sync_ff <= input_meta_ff;
    end
  end

  assign o_exec_ready = (state_ff == ST_IDLE);
  assign accept       = i_exec_valid & o_exec_ready;
  // Refresh only for the unsigned word compare; disabled unit refuses everything
  assign bad_req      = ~enable_ff | (i_exec_req.refresh &
                        (i_exec_req.op != OP_UNSIGNED_WORD));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept && !bad_req) begin
          nxt_state = i_exec_req.refresh ? ST_REFRESH : ST_COMPARE;
        end
      end
      ST_REFRESH: begin
        nxt_state = ST_COMPARE;
      end
      ST_COMPARE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Operand capture, then overwrite of input-mapped words during refresh
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_ff <= '0;
    end else if (accept && !bad_req) begin
      req_ff <= i_exec_req;
    end else if (state_ff == ST_REFRESH) begin
      if (req_ff.first_is_input) begin
        req_ff.first_operand.lower <= input_sync_ff;
      end
      if (req_ff.second_is_input) begin
        req_ff.second_operand.lower <= input_sync_ff;
      end
    end
  end

  assign nxt_flags = compare_fn(req_ff.op, req_ff.first_operand, req_ff.second_operand);

  // Arithmetic flags change only on a compare edge or a direct bus write
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_ff <= '0;
    end else if (state_ff == ST_COMPARE) begin
      flags_ff <= nxt_flags;
    end else if (flags_write) begin
      flags_ff <= i_avs_writedata[FLD_LE:FLD_GT];
    end
  end

  // Compares never touch these; they belong to other instructions
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      error_ff    <= 1'b0;
      negative_ff <= 1'b0;
    end else if (flags_write) begin
      error_ff    <= i_avs_writedata[FLD_ER];
      negative_ff <= i_avs_writedata[FLD_NEG];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      done_ff   <= 1'b0;
      reject_ff <= 1'b0;
    end else begin
      done_ff   <= (state_ff == ST_COMPARE);
      reject_ff <= accept & bad_req;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_ff <= COUNT_RESET;
    end else if (state_ff == ST_COMPARE) begin
      count_ff <= count_ff + COUNT_W'(1);
    end
  end

  assign o_flags          = flags_ff;
  assign o_error_flag_out = error_ff;
  assign o_negative_flag  = negative_ff;
  // Consumers gate flags with their launch condition and read after done
  assign o_done           = done_ff;
  assign o_reject         = reject_ff;

  // Avalon slave: one wait cycle, answer on the second cycle of the request
  assign bus_req           = i_avs_read | i_avs_write;
  assign bus_write         = i_avs_write & ack_ff;
  assign flags_write       = bus_write & (i_avs_address == FLAGS_OFFSET) & i_avs_byteenable[0];
  assign o_avs_waitrequest = bus_req & ~ack_ff;
  assign o_avs_readdata    = readdata_ff;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable_ff <= CONTROL_ENABLE_RESET;
    end else if (bus_write && i_avs_address == CONTROL_OFFSET && i_avs_byteenable[0]) begin
      enable_ff <= i_avs_writedata[FLD_ENABLE];
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      readdata_ff <= '0;
    end else if (i_avs_read && !ack_ff) begin
      case (i_avs_address)
        FLAGS_OFFSET:   readdata_ff <= {24'h000000, negative_ff, error_ff, flags_ff};
        CONTROL_OFFSET: readdata_ff <= {31'h00000000, enable_ff};
        COUNT_OFFSET:   readdata_ff <= {{(BUS_W-COUNT_W){1'b0}}, count_ff};
        SAMPLE_OFFSET:  readdata_ff <= {{(BUS_W-WORD_W){1'b0}}, input_sync_ff};
        default:        readdata_ff <= '0;
      endcase
    end
  end

  chk_unsigned_word_greater: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_UNSIGNED_WORD &&
     req_ff.first_operand.lower > req_ff.second_operand.lower)
    |=> (o_flags == 6'b001011))
    else $error("greater outcome pattern wrong");

  chk_unsigned_double_less: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_UNSIGNED_DOUBLE &&
     {req_ff.first_operand.upper, req_ff.first_operand.lower} <
     {req_ff.second_operand.upper, req_ff.second_operand.lower})
    |=> (o_flags.less_flag && o_flags.less_equal_flag && o_flags.not_equal_flag &&
         !o_flags.greater_flag && !o_flags.greater_equal_flag && !o_flags.equal_flag))
    else $error("double less outcome pattern wrong");

  chk_signed_word_equal: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_WORD &&
     req_ff.first_operand.lower == req_ff.second_operand.lower)
    |=> (o_flags == 6'b100110))
    else $error("equal outcome pattern wrong");

  chk_signed_word_sign: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_WORD &&
     req_ff.first_operand.lower[WORD_W-1] && !req_ff.second_operand.lower[WORD_W-1])
    |=> o_flags.less_flag)
    else $error("negative word not below positive word");

  chk_signed_double_sign: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_DOUBLE &&
     !req_ff.first_operand.upper[WORD_W-1] && req_ff.second_operand.upper[WORD_W-1])
    |=> o_flags.greater_flag)
    else $error("positive double not above negative double");

  chk_unsigned_word_equal: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_UNSIGNED_WORD &&
     req_ff.first_operand.lower == req_ff.second_operand.lower)
    |=> (o_flags == 6'b100110))
    else $error("word equal pattern wrong");

  chk_unsigned_word_less: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_UNSIGNED_WORD &&
     req_ff.first_operand.lower < req_ff.second_operand.lower)
    |=> (o_flags == 6'b111000))
    else $error("word less pattern wrong");

  chk_unsigned_double_greater: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_UNSIGNED_DOUBLE &&
     {req_ff.first_operand.upper, req_ff.first_operand.lower} >
     {req_ff.second_operand.upper, req_ff.second_operand.lower})
    |=> (o_flags == 6'b001011))
    else $error("double greater pattern wrong");

  chk_signed_double_equal: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_DOUBLE &&
     req_ff.first_operand == req_ff.second_operand)
    |=> (o_flags == 6'b100110))
    else $error("signed double equal pattern wrong");

  chk_signed_word_greater: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_WORD &&
     $signed(req_ff.first_operand.lower) > $signed(req_ff.second_operand.lower))
    |=> (o_flags == 6'b001011))
    else $error("signed word greater pattern wrong");

  // Equal upper halves: the lower halves decide as plain magnitudes
  chk_signed_double_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE && req_ff.op == OP_SIGNED_DOUBLE &&
     req_ff.first_operand.upper == req_ff.second_operand.upper &&
     req_ff.first_operand.lower > req_ff.second_operand.lower)
    |=> o_flags.greater_flag)
    else $error("lower half of signed double misread");

  chk_one_outcome: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_done |-> ($onehot({o_flags.greater_flag, o_flags.equal_flag, o_flags.less_flag}) &&
                o_flags.greater_equal_flag == !o_flags.less_flag &&
                o_flags.less_equal_flag == !o_flags.greater_flag &&
                o_flags.not_equal_flag == !o_flags.equal_flag))
    else $error("flags do not form one outcome");

  chk_side_flags_kept: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff != ST_IDLE && !flags_write)
    |=> ($stable(o_error_flag_out) && $stable(o_negative_flag)))
    else $error("compare disturbed error or negative flag");

  chk_refresh_sample: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_REFRESH && req_ff.first_is_input)
    |=> (req_ff.first_operand.lower == $past(input_sync_ff) && state_ff == ST_COMPARE))
    else $error("refresh did not load the sampled input word");

  chk_refresh_second: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_REFRESH && req_ff.second_is_input)
    |=> (req_ff.second_operand.lower == $past(input_sync_ff)))
    else $error("refresh did not load the second operand");

  chk_refresh_accepted: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (accept && !bad_req && i_exec_req.refresh)
    |=> (state_ff == ST_REFRESH))
    else $error("refreshing word compare not taken");

  chk_refresh_refused: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (accept && i_exec_req.refresh && i_exec_req.op != OP_UNSIGNED_WORD)
    |=> (o_reject && state_ff == ST_IDLE) ##1 !o_done)
    else $error("refresh on other compare was not refused");

  chk_flags_held: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff != ST_COMPARE && !flags_write) |=> $stable(o_flags))
    else $error("flags changed without a compare");

  chk_done_follows: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_ff == ST_COMPARE) |=> o_done)
    else $error("no done after flags were written");

endmodule

// ==== compare_pkg.sv ====
// Constants, types and register map of the binary compare flag unit.
// Contract
// - Unsigned word compare treats both operands as 16-bit unsigned and sets six flags.
// - Unsigned double compare joins next-address word as upper half, compares 32-bit.
// - Double operands use two consecutive words from the low word; word ops use one.
// - First above second sets greater, greater-equal, not-equal; clears the other three.
// - First below second sets less, less-equal, not-equal; clears the other three.
// - Equal operands set equal, greater-equal, less-equal; clear the other three.
// - Every compare rewrites all six flags; exactly one outcome pattern remains.
// - Unsigned compares leave error and negative flags untouched.
// - Refreshing variant is accepted only for the unsigned word compare.
// - Refreshing variant re-samples the input word first, then compares that value.
// - Signed word compare treats 16-bit operands as two's complement.
// - Signed double compare treats 32-bit operands from two words as two's complement.
// - Signed double upper half is operand address plus one, lower half the address.
// - Unsigned double compare has no refreshing variant.
package compare_pkg;

  localparam int WORD_W = 16;
  localparam int BUS_W  = 32;
  localparam int ADDR_W = 4;
  localparam int COUNT_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] FLAGS_OFFSET   = 4'h0;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET   = 4'h8;
  localparam logic [ADDR_W-1:0] SAMPLE_OFFSET  = 4'hC;

  // Field positions in the flags and control registers
  localparam int FLD_GT  = 0;
  localparam int FLD_GE  = 1;
  localparam int FLD_EQ  = 2;
  localparam int FLD_NE  = 3;
  localparam int FLD_LT  = 4;
  localparam int FLD_LE  = 5;
  localparam int FLD_ER  = 6;
  localparam int FLD_NEG = 7;
  localparam int FLD_ENABLE = 0;

  localparam logic CONTROL_ENABLE_RESET = 1'b1;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    OP_UNSIGNED_WORD   = 2'b00,
    OP_UNSIGNED_DOUBLE = 2'b01,
    OP_SIGNED_WORD     = 2'b10,
    OP_SIGNED_DOUBLE   = 2'b11
  } compare_op_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_REFRESH = 2'b01,
    ST_COMPARE = 2'b10
  } compare_state_t;

  // Upper word sits at operand address plus one
  typedef struct packed {
    logic [WORD_W-1:0] upper;
    logic [WORD_W-1:0] lower;
  } operand_t;

  typedef struct packed {
    compare_op_t op;
    logic        refresh;
    logic        first_is_input;
    logic        second_is_input;
    operand_t    first_operand;
    operand_t    second_operand;
  } compare_req_t;

  typedef struct packed {
    logic less_equal_flag;
    logic less_flag;
    logic not_equal_flag;
    logic equal_flag;
    logic greater_equal_flag;
    logic greater_flag;
  } result_flags_t;

endpackage

// ==== sequencer_model.sv ====
// Behavioural instruction sequencer feeding one compare at a time.
`timescale 1ns/10ps
module sequencer_model (
  input  wire logic                       i_clock,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_start,
  input  wire compare_pkg::compare_req_t  i_req,
  input  wire logic                       i_exec_ready,
  input  wire logic                       i_done,
  input  wire logic                       i_reject,
  input  wire compare_pkg::result_flags_t i_flags,
  output logic                            o_exec_valid,
  output compare_pkg::compare_req_t       o_exec_req,
  output logic                            o_busy,
  output logic                            o_rejected,
  output logic                            o_equal_hit
);
  import compare_pkg::*;

  // No new request until the previous one answered, so nothing disturbs the flags
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_exec_valid <= 1'b0;
      o_busy       <= 1'b0;
      o_rejected   <= 1'b0;
      o_exec_req   <= '0;
    end else if (i_start && !o_busy) begin
      o_exec_valid <= 1'b1;
      o_exec_req   <= i_req;
      o_busy       <= 1'b1;
      o_rejected   <= 1'b0;
    end else if (o_exec_valid && i_exec_ready) begin
      o_exec_valid <= 1'b0;
      // Released bus shows garbage, not the last request
      o_exec_req   <= compare_req_t'(~o_exec_req);
    end else if (o_busy && (i_done || i_reject)) begin
      o_busy       <= 1'b0;
      o_rejected   <= i_reject;
    end
  end

  // Consumer only acts in the cycle its own compare completed
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_equal_hit <= 1'b0;
    end else begin
      o_equal_hit <= i_done & i_flags.equal_flag;
    end
  end
endmodule

// ==== binary_compare_flag_unit_tb.sv ====
// Self-checking bench: register access and compare sequences.
`timescale 1ns/10ps
module binary_compare_flag_unit_tb;
  import compare_pkg::*;

  logic clock, reset_n, start, ready, valid, done, reject, busy, rejected;
  logic err_flag, neg_flag, av_rd, av_wr, waitreq, equal_hit;
  logic [ADDR_W-1:0] av_addr;
  logic [BUS_W-1:0]  av_wdata, av_rdata, rd, hits;
  logic [3:0]        av_be;
  logic [WORD_W-1:0] in_word;
  compare_req_t  req, exec_req;
  result_flags_t flags, want;
  int fail_count, n_tests, cycles, n_done;
  compare_op_t   ops[13] = '{OP_UNSIGNED_WORD, OP_UNSIGNED_WORD, OP_UNSIGNED_WORD,
    OP_UNSIGNED_DOUBLE, OP_UNSIGNED_DOUBLE, OP_UNSIGNED_DOUBLE, OP_SIGNED_WORD,
    OP_SIGNED_WORD, OP_SIGNED_DOUBLE, OP_SIGNED_DOUBLE, OP_SIGNED_DOUBLE, OP_SIGNED_WORD,
    OP_SIGNED_DOUBLE};
  logic [31:0] va[13] = '{32'hFFFF_0005, 32'h0000_1234, 32'h0000_0000, 32'h0001_0000,
    32'hDEAD_BEEF, 32'h7FFF_FFFF, 32'h0000_8000, 32'h0000_FFFF, 32'h8000_0000,
    32'h0000_0000, 32'hCAFE_0001, 32'h1234_8001, 32'hFFFF_8000};
  logic [31:0] vb[13] = '{32'h0000_0003, 32'h5555_1234, 32'h0000_FFFF, 32'h0000_FFFF,
    32'hDEAD_BEEF, 32'h8000_0000, 32'h0000_0001, 32'h0000_FFFE, 32'h7FFF_FFFF,
    32'hFFFF_FFFF, 32'hCAFE_0001, 32'h0000_8001, 32'hFFFF_0001};

  binary_compare_flag_unit u_binary_compare_flag_unit (
    .i_clock(clock), .i_reset_n(reset_n), .i_exec_valid(valid), .o_exec_ready(ready),
    .i_exec_req(exec_req), .o_done(done), .o_reject(reject), .i_input_word(in_word),
    .o_flags(flags), .o_error_flag_out(err_flag), .o_negative_flag(neg_flag),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(waitreq));

  sequencer_model u_sequencer_model (
    .i_clock(clock), .i_reset_n(reset_n), .i_start(start), .i_req(req),
    .i_exec_ready(ready), .i_done(done), .i_reject(reject), .i_flags(flags),
    .o_exec_valid(valid), .o_exec_req(exec_req), .o_busy(busy), .o_rejected(rejected),
    .o_equal_hit(equal_hit));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the roughly 160 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
    @(posedge clock);
    av_addr <= a;
    av_rd   <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    d = av_rdata;
    av_rd <= 1'b0;
  endtask

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                        input logic [3:0] be);
    @(posedge clock);
    av_addr  <= a;
    av_wdata <= d;
    av_be    <= be;
    av_wr    <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    av_wr <= 1'b0;
  endtask

  function automatic result_flags_t exp_flags(compare_op_t op, logic [31:0] a, logic [31:0] b);
    logic gt;
    logic eq;
    case (op)
      OP_UNSIGNED_WORD:   gt = a[15:0] > b[15:0];
      OP_UNSIGNED_DOUBLE: gt = a > b;
      OP_SIGNED_WORD:     gt = $signed(a[15:0]) > $signed(b[15:0]);
      default:            gt = $signed(a) > $signed(b);
    endcase
    eq = op[0] ? (a == b) : (a[15:0] == b[15:0]);
    return result_flags_t'({!gt, !gt && !eq, !eq, eq, gt || eq, gt});
  endfunction

  // Mark bits: refresh first operand, refresh second operand
  task automatic run_cmp(input compare_op_t op, input logic [1:0] rf, input logic [31:0] a,
                         input logic [31:0] b);
    @(posedge clock);
    req   <= compare_req_t'({op, |rf, rf, a, b});
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do @(posedge clock); while (busy !== 1'b0);
  endtask

  initial begin
    reset_n = 1'b0; start = 1'b0; req = '0; in_word = 16'h0000;
    av_rd = 1'b0; av_wr = 1'b0; av_addr = '0; av_wdata = '0; av_be = 4'hF;
    fail_count = 0; n_tests = 0; cycles = 0; n_done = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    bus_rd(FLAGS_OFFSET, rd);   check("flags reset", rd, 32'h0000_0000);
    bus_rd(CONTROL_OFFSET, rd); check("control reset", rd, 32'h0000_0001);
    bus_rd(COUNT_OFFSET, rd);   check("count reset", rd, 32'h0000_0000);
    bus_rd(4'h2, rd);           check("unmapped read", rd, 32'h0000_0000);
    bus_wr(COUNT_OFFSET, 32'h0000_00FF, 4'hF);
    bus_wr(CONTROL_OFFSET, 32'h0000_0000, 4'h0);
    bus_rd(CONTROL_OFFSET, rd); check("control no lanes", rd, 32'h0000_0001);
    // Preset error and negative so any unwanted clearing shows
    bus_wr(FLAGS_OFFSET, 32'h0000_00C0, 4'hF);
    for (int i = 0; i < 13; i++) begin
      run_cmp(ops[i], 2'b00, va[i], vb[i]);
      n_done++;
      want = exp_flags(ops[i], va[i], vb[i]);
      check("flags", 32'(flags), 32'(want));
      hits = 32'(flags.greater_flag) + 32'(flags.equal_flag) + 32'(flags.less_flag);
      check("one outcome", hits, 32'h1);
      check("equal hit", 32'(equal_hit), 32'(want.equal_flag));
      check("error kept", 32'(err_flag), 32'h1);
      check("negative kept", 32'(neg_flag), 32'h1);
      check("rejected", 32'(rejected), 32'h0);
    end
    bus_rd(FLAGS_OFFSET, rd); check("flags reg", rd, {24'h0, 2'b11, want});
    // Refreshed compare uses the live input word, not the stored low word
    in_word <= 16'h9000;
    repeat (4) @(posedge clock);
    bus_rd(SAMPLE_OFFSET, rd); check("sample", rd, 32'h0000_9000);
    run_cmp(OP_UNSIGNED_WORD, 2'b10, 32'h0000_0001, 32'h0000_9000);
    n_done++;
    want = exp_flags(OP_UNSIGNED_WORD, 32'h0000_9000, 32'h0000_9000);
    check("refresh flags", 32'(flags), 32'(want));
    check("refresh taken", 32'(rejected), 32'h0);
    run_cmp(OP_UNSIGNED_WORD, 2'b01, 32'h0000_9000, 32'h0000_0001);
    n_done++;
    check("refresh second", 32'(flags), 32'(want));
    check("refresh hit", 32'(equal_hit), 32'h1);
    // Refresh on any other operation is refused and leaves flags alone
    for (int k = 1; k < 4; k++) begin
      run_cmp(compare_op_t'(k), 2'b10, 32'h0000_0000, 32'h0000_0001);
      check("refresh refused", 32'(rejected), 32'h1);
      check("no hit", 32'(equal_hit), 32'h0);
      check("flags held", 32'(flags), 32'(want));
    end
    bus_wr(CONTROL_OFFSET, 32'h0000_0000, 4'h1);
    run_cmp(OP_UNSIGNED_WORD, 2'b00, 32'h0000_0002, 32'h0000_0001);
    check("disabled refused", 32'(rejected), 32'h1);
    check("disabled flags", 32'(flags), 32'(want));
    bus_wr(CONTROL_OFFSET, 32'h0000_0001, 4'h1);
    bus_rd(COUNT_OFFSET, rd); check("count", rd, 32'(n_done));
    conclude();
  end
endmodule
